// ==== hw/dma_end_pkg.sv ====
// Package: register map, field positions, timing counts and carriers for the DMA request engine
package dma_end_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_GLOBAL = 5'h04;
	localparam logic [4:0] OFS_SRC    = 5'h08;
	localparam logic [4:0] OFS_DST    = 5'h0C;
	localparam logic [4:0] OFS_COUNT  = 5'h10;
	localparam logic [4:0] OFS_PSRC   = 5'h14;
	localparam logic [4:0] OFS_STATUS = 5'h18;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CB_ENABLE   = 0;
	localparam int CB_BURST    = 1;
	localparam int CB_EDGE     = 2;
	localparam int CB_RELOAD   = 3;
	localparam int CB_INT_EN   = 4;
	localparam int CB_ACK_WR   = 5;
	localparam int CB_SIZE_LO  = 6;
	localparam int CB_END_FLAG = 8;
	localparam int GB_MASTER   = 0;
	localparam int GB_NMI      = 1;
	localparam int GB_ADDR_ERR = 2;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [31:0] REG_RST     = 32'h0000_0000;
	localparam logic [1:0]  SIZE_16BYTE = 2'h3;
	localparam logic [1:0]  SAMPLE_AHEAD = 2'h2;
	localparam logic [1:0]  START_DELAY  = 2'h3;
	localparam logic [1:0]  RELOAD_LAST  = 2'h3;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} ahb_rsp_t;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_WAIT  = 5'h02,
		ST_READ  = 5'h04,
		ST_WRITE = 5'h08,
		ST_GAP   = 5'h10
	} phase_t;

endpackage : dma_end_pkg

// ==== hw/dma_request_engine.sv ====
// DMA channel: request sampling, acknowledge, source reload and ending control
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/10ps

module dma_request_engine
	import dma_end_pkg::*;
#(
	parameter int ACC_STATES = 2
)
(
	input  wire logic                  clk,                    // 20 MHz bus clock
	input  wire logic                  rst,                    // Async reset, high
	input  wire dma_end_pkg::ahb_req_t ahb_in,                 // AHB-Lite request
	output      dma_end_pkg::ahb_rsp_t ahb_out,                // AHB-Lite response
	input  wire logic                  xfer_request_n,         // Request pin, low active
	input  wire logic                  nmi_in,                 // NMI pin, high active
	input  wire logic                  address_error_in,       // Address error pulse
	output      logic                  chip_select_n,          // Access strobe, low
	output      logic                  xfer_acknowledge,       // Acknowledge, high
	output      logic                  end_interrupt_request,  // End interrupt
	output      logic                  bus_hold,               // DMA owns the bus
	output      logic                  dma_write,              // Write half active
	output      logic [31:0]           dma_address             // Access address
);
	import dma_end_pkg::*;

	typedef struct packed {
		phase_t      ph;
		logic [1:0]  dly;
		logic [3:0]  acc;
		logic        pend;
		logic        hunt;
		logic        brun;
		logic        edge_lat;
		logic        req_s1;
		logic        req_s2;
		logic        req_prev;
		logic        nmi_s1;
		logic        nmi_s2;
		logic        nmi_prev;
		logic        channel_enable;
		logic        burst_mode;
		logic        edge_detect;
		logic        reload_enable;
		logic        end_interrupt_enable;
		logic        ack_on_write;
		logic [1:0]  unit_size;
		logic        transfer_end_flag;
		logic        master_enable;
		logic        nmi_suspend_flag;
		logic        address_error_flag;
		logic [31:0] src;
		logic [31:0] psrc;
		logic [31:0] dst;
		logic [31:0] cnt;
		logic [1:0]  rld;
		logic        dph;
		logic [4:0]  waddr;
		logic [31:0] rdata;
		logic        cs_n;
		logic        ack;
		logic        irq;
		logic        hold;
		logic        dwr;
		logic [31:0] daddr;
	} state_t;

	localparam logic [3:0] ACC_LAST = 4'(ACC_STATES - 1);

	state_t s_ff;
	state_t nxt_s;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] unit_bytes(input logic [1:0] sz);
		unique case (sz)
			2'h0:    unit_bytes = 32'h0000_0001;
			2'h1:    unit_bytes = 32'h0000_0002;
			2'h2:    unit_bytes = 32'h0000_0004;
			default: unit_bytes = 32'h0000_0010;
		endcase
	endfunction : unit_bytes

	function automatic logic [31:0] read_word(input state_t v, input logic [4:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (a)
			OFS_CTRL:
			begin
				w[CB_ENABLE]              = v.channel_enable;
				w[CB_BURST]               = v.burst_mode;
				w[CB_EDGE]                = v.edge_detect;
				w[CB_RELOAD]              = v.reload_enable;
				w[CB_INT_EN]              = v.end_interrupt_enable;
				w[CB_ACK_WR]              = v.ack_on_write;
				w[CB_SIZE_LO +: 2]        = v.unit_size;
				w[CB_END_FLAG]            = v.transfer_end_flag;
			end
			OFS_GLOBAL:
			begin
				w[GB_MASTER]              = v.master_enable;
				w[GB_NMI]                 = v.nmi_suspend_flag;
				w[GB_ADDR_ERR]            = v.address_error_flag;
			end
			OFS_SRC:    w = v.src;
			OFS_DST:    w = v.dst;
			OFS_COUNT:  w = v.cnt;
			OFS_PSRC:   w = v.psrc;
			OFS_STATUS: w = {21'h0, v.rld, v.brun, v.hunt, v.pend, 1'b0, v.ph};
			default:    w = 32'h0000_0000;
		endcase
		read_word = w;
	endfunction : read_word

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic fall;
	logic stop;
	logic seen;
	logic hit;
	logic samp;
	logic accept;
	logic end_set;
	logic nmi_set;
	logic reload_on;
	logic rd_take;
	logic [31:0] wd;

	always_comb
	begin
		nxt_s     = s_ff;
		wd        = ahb_in.hwdata;
		end_set   = 1'b0;
		// Pins pass two flops before any logic looks at them
		nxt_s.req_s1   = xfer_request_n;
		nxt_s.req_s2   = s_ff.req_s1;
		nxt_s.req_prev = s_ff.req_s2;
		nxt_s.nmi_s1   = nmi_in;
		nxt_s.nmi_s2   = s_ff.nmi_s1;
		nxt_s.nmi_prev = s_ff.nmi_s2;
		nmi_set   = s_ff.nmi_s2 & ~s_ff.nmi_prev;
		reload_on = s_ff.reload_enable & (s_ff.unit_size != SIZE_16BYTE);

		// low level or latched falling edge
		fall = s_ff.req_prev & ~s_ff.req_s2;
		seen = s_ff.edge_detect ? (s_ff.edge_lat | fall) : ~s_ff.req_s2;
		stop = ~s_ff.channel_enable | ~s_ff.master_enable
			| s_ff.nmi_suspend_flag | s_ff.address_error_flag;
		// running edge burst needs no request
		hit = (s_ff.brun & s_ff.burst_mode & s_ff.edge_detect) | seen;
		samp = (s_ff.ph == ST_IDLE) | (s_ff.ph == ST_GAP) | s_ff.hunt
			| ((s_ff.ph == ST_WAIT) & (s_ff.dly == SAMPLE_AHEAD));
		accept = samp & hit & ~stop & (s_ff.cnt != 32'h0000_0000);
		nxt_s.edge_lat = (s_ff.edge_lat | fall) & ~samp;
		if (samp & stop)
			nxt_s.brun = 1'b0;

		if (s_ff.hunt)
		begin
			nxt_s.hunt = ~accept & ~stop;
			if (accept)
				nxt_s.pend = 1'b1;
		end

		unique case (s_ff.ph)
			ST_IDLE:
			begin
				nxt_s.brun = 1'b0;
				nxt_s.pend = 1'b0;
				nxt_s.hunt = 1'b0;
				if (accept)
				begin
					nxt_s.ph   = ST_WAIT;
					nxt_s.dly  = 2'h1;
					nxt_s.brun = s_ff.burst_mode & s_ff.edge_detect;
				end
			end
			ST_WAIT:
			begin
				nxt_s.dly = s_ff.dly + 2'h1;
				if (s_ff.dly == SAMPLE_AHEAD)
				begin
					nxt_s.pend = accept;
					nxt_s.hunt = ~hit & ~stop;
				end
				if (s_ff.dly == START_DELAY - 2'h1)
				begin
					nxt_s.ph  = ST_READ;
					nxt_s.acc = 4'h0;
				end
			end
			ST_READ:
			begin
				nxt_s.acc = s_ff.acc + 4'h1;
				if (s_ff.acc == ACC_LAST)
				begin
					nxt_s.ph  = ST_WRITE;
					nxt_s.acc = 4'h0;
				end
			end
			ST_WRITE:
			begin
				nxt_s.acc = s_ff.acc + 4'h1;
				if (s_ff.acc == ACC_LAST)
				begin
					nxt_s.ph  = ST_GAP;
					nxt_s.cnt = s_ff.cnt - 32'h0000_0001;
					if (reload_on & (s_ff.rld == RELOAD_LAST))
						nxt_s.src = s_ff.psrc;
					else
						nxt_s.src = s_ff.src + unit_bytes(s_ff.unit_size);
					if (reload_on)
						nxt_s.rld = s_ff.rld + 2'h1;
					if (s_ff.cnt == 32'h0000_0001)
					begin
						end_set    = 1'b1;
						nxt_s.pend = 1'b0;
						nxt_s.hunt = 1'b0;
						nxt_s.brun = 1'b0;
					end
				end
			end
			ST_GAP:
			begin
				// third sample in this idle cycle
				nxt_s.hunt = 1'b0;
				if (s_ff.pend & (s_ff.cnt != 32'h0000_0000))
				begin
					nxt_s.ph   = ST_READ;
					nxt_s.acc  = 4'h0;
					nxt_s.pend = accept;
					nxt_s.hunt = ~hit & ~stop;
				end
				else if (accept)
				begin
					nxt_s.ph   = ST_WAIT;
					nxt_s.dly  = 2'h1;
					nxt_s.pend = 1'b0;
				end
				else
				begin
					nxt_s.ph   = ST_IDLE;
					nxt_s.pend = 1'b0;
				end
			end
			default:
			begin
				nxt_s.ph   = ST_IDLE;
				nxt_s.pend = 1'b0;
				nxt_s.hunt = 1'b0;
			end
		endcase

		// ------------------------------------------------------------
		// Register writes, data phase
		// ------------------------------------------------------------
		if (s_ff.dph)
		begin
			unique case (s_ff.waddr)
				OFS_CTRL:
				begin
					nxt_s.channel_enable       = wd[CB_ENABLE];
					nxt_s.burst_mode           = wd[CB_BURST];
					nxt_s.edge_detect          = wd[CB_EDGE];
					nxt_s.reload_enable        = wd[CB_RELOAD];
					nxt_s.end_interrupt_enable = wd[CB_INT_EN];
					nxt_s.ack_on_write         = wd[CB_ACK_WR];
					nxt_s.unit_size            = wd[CB_SIZE_LO +: 2];
					// Flag clears on a written zero only
					nxt_s.transfer_end_flag    = s_ff.transfer_end_flag & wd[CB_END_FLAG];
				end
				OFS_GLOBAL:
				begin
					nxt_s.master_enable      = wd[GB_MASTER];
					nxt_s.nmi_suspend_flag   = s_ff.nmi_suspend_flag & wd[GB_NMI];
					nxt_s.address_error_flag = s_ff.address_error_flag & wd[GB_ADDR_ERR];
				end
				OFS_SRC:
				begin
					nxt_s.src  = wd;
					nxt_s.psrc = wd;
				end
				OFS_DST:   nxt_s.dst = wd;
				OFS_COUNT: nxt_s.cnt = wd;
				default:   nxt_s.dst = nxt_s.dst;
			endcase
		end

		// Hardware sets win over a same-cycle clear
		if (end_set)
			nxt_s.transfer_end_flag = 1'b1;
		if (nmi_set)
			nxt_s.nmi_suspend_flag = 1'b1;
		if (address_error_in)
			nxt_s.address_error_flag = 1'b1;
		// reload counter back to zero
		// Held while a suspend flag stands: late units leave no stale count
		if (~s_ff.master_enable | ~s_ff.channel_enable | end_set
			| nmi_set | address_error_in
			| s_ff.nmi_suspend_flag | s_ff.address_error_flag)
			nxt_s.rld = 2'h0;

		// ------------------------------------------------------------
		// Address phase; read data reflects writes just applied
		// ------------------------------------------------------------
		rd_take     = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready & ~ahb_in.hwrite;
		nxt_s.dph   = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready & ahb_in.hwrite;
		nxt_s.waddr = ahb_in.haddr[4:0];
		nxt_s.rdata = rd_take ? read_word(nxt_s, ahb_in.haddr[4:0]) : 32'h0000_0000;

		// ------------------------------------------------------------
		// Registered outputs
		// ------------------------------------------------------------
		nxt_s.cs_n  = ~((nxt_s.ph == ST_READ) | (nxt_s.ph == ST_WRITE));
		nxt_s.ack   = nxt_s.ack_on_write ? (nxt_s.ph == ST_WRITE)
			: (nxt_s.ph == ST_READ);
		nxt_s.dwr   = nxt_s.ph == ST_WRITE;
		nxt_s.daddr = (nxt_s.ph == ST_WRITE) ? nxt_s.dst : nxt_s.src;
		// Cycle steal hands the bus back in the gap
		nxt_s.hold  = (nxt_s.ph != ST_IDLE)
			& ~((nxt_s.ph == ST_GAP) & ~nxt_s.burst_mode);
		nxt_s.irq   = nxt_s.transfer_end_flag & nxt_s.end_interrupt_enable;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_ff          <= '0;
			s_ff.ph       <= ST_IDLE;
			s_ff.req_s1   <= 1'b1;
			s_ff.req_s2   <= 1'b1;
			s_ff.req_prev <= 1'b1;
			s_ff.src      <= REG_RST;
			s_ff.cs_n     <= 1'b1;
		end
		else
			s_ff <= nxt_s;
	end

	assign ahb_out.hrdata    = s_ff.rdata;
	assign ahb_out.hreadyout = 1'b1;
	assign ahb_out.hresp     = 1'b0;
	assign chip_select_n         = s_ff.cs_n;
	assign xfer_acknowledge      = s_ff.ack;
	assign end_interrupt_request = s_ff.irq;
	assign bus_hold              = s_ff.hold;
	assign dma_write             = s_ff.dwr;
	assign dma_address           = s_ff.daddr;

endmodule : dma_request_engine

// ==== testbench/dma_request_engine_sva.sv ====
// Checker: port timing assertions for the DMA request engine
`timescale 1ns/10ps
module dma_request_engine_sva
	import dma_end_pkg::*;
#(
	parameter int ACC_STATES = 2
)
(
	input wire logic                  clk,                   // Bus clock
	input wire logic                  rst,                   // Async reset
	input wire dma_end_pkg::ahb_req_t ahb_in,                // Bus request
	input wire dma_end_pkg::ahb_rsp_t ahb_out,               // Bus response
	input wire logic                  xfer_request_n,        // Request pin
	input wire logic                  nmi_in,                // NMI pin
	input wire logic                  address_error_in,      // Address error
	input wire logic                  chip_select_n,         // Access strobe
	input wire logic                  xfer_acknowledge,      // Acknowledge
	input wire logic                  end_interrupt_request, // End interrupt
	input wire logic                  bus_hold,              // Bus owned
	input wire logic                  dma_write,             // Write half
	input wire logic [31:0]           dma_address            // Access address
);
	logic [7:0] cs_run_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// Strobe run length
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cs_run_ff <= 8'h00;
		else
			cs_run_ff <= chip_select_n ? 8'h00 : cs_run_ff + 8'h01;
	end
	sequence read_half;
		!chip_select_n && !dma_write;
	endsequence
	sequence write_half;
		!chip_select_n && dma_write;
	endsequence
	AST_UNIT_ORDER:
		assert property ($fell(chip_select_n) |-> read_half[*2] ##1 write_half[*2] ##1 chip_select_n)
		else $error("unit not read then write");
	AST_UNIT_LEN:
		assert property ($rose(chip_select_n) |-> cs_run_ff == 2 * ACC_STATES)
		else $error("unit strobe length wrong");
	AST_WRITE_IN_CS:
		assert property (dma_write |-> !chip_select_n && bus_hold)
		else $error("write half outside access");
	AST_ACK_IN_CS:
		assert property (xfer_acknowledge |-> !chip_select_n)
		else $error("acknowledge outside strobe");
	AST_ACK_LEN:
		assert property ($rose(xfer_acknowledge) |-> xfer_acknowledge[*2] ##1 !xfer_acknowledge)
		else $error("acknowledge length wrong");
	AST_ACK_START:
		assert property ($rose(xfer_acknowledge) |-> $changed(dma_write) || $fell(chip_select_n))
		else $error("acknowledge not at half start");
	AST_NMI_STOP:
		assert property ($rose(nmi_in) |-> ##[1:24] (!bus_hold)[*8])
		else $error("no stop after nmi");
	AST_AERR_STOP:
		assert property (address_error_in |-> ##[1:24] (!bus_hold)[*8])
		else $error("no stop after address error");
	AST_RESET_IDLE:
		assert property ($fell(rst) |-> chip_select_n && !bus_hold && !xfer_acknowledge)
		else $error("busy right after reset");
endmodule : dma_request_engine_sva

// ==== testbench/dma_peripheral_model.sv ====
// Partner: external peripheral raising requests and counting acknowledges
`timescale 1ns/10ps
module dma_peripheral_model
(
	input  wire logic       clk,              // Bus clock
	input  wire logic       rst,              // Async reset
	input  wire logic       start,            // Begin a request
	input  wire logic       edge_mode,        // Single falling edge
	input  wire logic [3:0] delay,            // Cycles before request
	input  wire logic [7:0] units,            // Units wanted
	input  wire logic       xfer_acknowledge, // Acknowledge in
	output      logic       xfer_request_n,   // Request pin
	output      logic [7:0] acks              // Acknowledges seen
);
	logic       ack_ff;
	logic       armed_ff;
	logic [3:0] wait_ff;
	logic [7:0] left_ff;
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			xfer_request_n <= 1'b1;
			acks <= 8'h00;
			ack_ff <= 1'b0;
			armed_ff <= 1'b0;
		end
		else
		begin
			ack_ff <= xfer_acknowledge;
			if (xfer_acknowledge && !ack_ff)
				acks <= acks + 8'h01;
			if (start)
			begin
				// Pulled-up pin idles high
				xfer_request_n <= 1'b1;
				armed_ff <= 1'b1;
				wait_ff <= delay;
				left_ff <= units;
				acks <= 8'h00;
			end
			else if (armed_ff && wait_ff != 4'h0)
				wait_ff <= wait_ff - 4'h1;
			else if (armed_ff)
			begin
				xfer_request_n <= 1'b0;
				armed_ff <= 1'b0;
			end
			else if (edge_mode || (xfer_acknowledge && !ack_ff && acks + 8'h01 == left_ff))
				xfer_request_n <= 1'b1;
		end
	end
endmodule : dma_peripheral_model

// ==== testbench/test_dma_request_engine.sv ====
// Testbench: register access, request modes and stop cases
`timescale 1ns/10ps
module test_dma_request_engine;
	import dma_end_pkg::*;
	localparam logic [8:0]  RUN_CTRL [3] = '{9'h091, 9'h02F, 9'h043};
	localparam logic [7:0]  RUN_CNT [3]  = '{8'h04, 8'h08, 8'h04};
	localparam logic [3:0]  RUN_DLY [3]  = '{4'h0, 4'h1, 4'h3};
	localparam logic [31:0] RUN_SRC [3]  = '{32'h0000_1010, 32'h0000_1000, 32'h0000_1008};
	localparam logic [8:0]  STOP_CTRL [4] = '{9'h089, 9'h08F, 9'h08F, 9'h08B};
	localparam logic [31:0] STOP_GLB [4]  = '{32'h1, 32'h0, 32'h3, 32'h5};
	logic        clk, rst, nmi_in, address_error_in, start, edge_mode, ack_wr_exp;
	logic        xfer_request_n, chip_select_n, xfer_acknowledge, end_interrupt_request;
	logic        bus_hold, dma_write;
	logic [31:0] dma_address, rd;
	logic [7:0]  units, acks;
	logic [3:0]  delay;
	ahb_req_t    ahb_in;
	ahb_rsp_t    ahb_out;
	int          err_count = 0;
	int          tests_run = 0;
	dma_request_engine dma_request_engine_i (.clk(clk), .rst(rst), .ahb_in(ahb_in),
		.ahb_out(ahb_out), .xfer_request_n(xfer_request_n), .nmi_in(nmi_in),
		.address_error_in(address_error_in), .chip_select_n(chip_select_n),
		.xfer_acknowledge(xfer_acknowledge), .end_interrupt_request(end_interrupt_request),
		.bus_hold(bus_hold), .dma_write(dma_write), .dma_address(dma_address));
	dma_peripheral_model dma_peripheral_model_i (.clk(clk), .rst(rst), .start(start),
		.edge_mode(edge_mode), .delay(delay), .units(units),
		.xfer_acknowledge(xfer_acknowledge), .xfer_request_n(xfer_request_n), .acks(acks));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [4:0] ofs, input logic [31:0] wd);
		@(posedge clk);
		ahb_in.hsel <= 1'b1;
		ahb_in.haddr <= {27'h0, ofs};
		ahb_in.htrans <= 2'h2;
		ahb_in.hwrite <= wr;
		ahb_in.hsize <= 3'h2;
		do @(posedge clk); while (ahb_out.hreadyout !== 1'b1);
		ahb_in.hsel <= 1'b0;
		ahb_in.htrans <= 2'h0;
		ahb_in.hwdata <= wd;
		do @(posedge clk); while (ahb_out.hreadyout !== 1'b1);
		rd = ahb_out.hrdata;
	endtask : bus
	task automatic expect_reg(input string name, input logic [4:0] ofs, input logic [31:0] exp);
		bus(1'b0, ofs, 32'h0);
		check(name, rd, exp);
		check("hresp", {31'h0, ahb_out.hresp}, 32'h0);
	endtask : expect_reg
	task automatic go(input logic [8:0] ctrl, input logic [7:0] cnt, input logic [3:0] dl);
		int n;
		n = 0;
		// Start held high keeps the pin released while programming
		units <= cnt;
		delay <= dl;
		edge_mode <= ctrl[2];
		start <= 1'b1;
		bus(1'b1, OFS_SRC, 32'h0000_1000);
		bus(1'b1, OFS_DST, 32'h0000_2000);
		bus(1'b1, OFS_COUNT, {24'h0, cnt});
		bus(1'b1, OFS_GLOBAL, 32'h1); // flags cleared first
		bus(1'b1, OFS_CTRL, {23'h0, ctrl});
		ack_wr_exp = ctrl[5];
		@(posedge clk);
		start <= 1'b0;
		while (xfer_request_n !== 1'b0) @(negedge clk);
		while (chip_select_n !== 1'b0)
		begin
			@(negedge clk);
			n++;
		end
		check("req_to_cs", {31'h0, n >= 3 && n <= 12}, 32'h1);
	endtask : go
	task automatic wait_end();
		rd = 32'h0;
		for (int i = 0; i < 100 && rd[8] !== 1'b1; i++)
			bus(1'b0, OFS_CTRL, 32'h0);
		check("end_flag", rd[8], 1'b1);
	endtask : wait_end
	task automatic complete_run();
		if (err_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	// Acknowledge must sit in the selected half
	always @(negedge clk)
	begin
		if (xfer_acknowledge === 1'b1)
			check("ack_half", dma_write, ack_wr_exp);
		if (dma_write === 1'b1)
			check("dst_addr", dma_address, 32'h0000_2000);
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		err_count++;
		complete_run();
	end
	initial
	begin
		rst = 1'b1;
		{nmi_in, address_error_in, start, edge_mode, ack_wr_exp} = 5'h00;
		units = 8'h00;
		delay = 4'h0;
		ahb_in = '0;
		ahb_in.hready = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		expect_reg("ctrl_rst", OFS_CTRL, REG_RST);
		expect_reg("global_rst", OFS_GLOBAL, REG_RST);
		expect_reg("status_rst", OFS_STATUS, 32'h0000_0001);
		bus(1'b1, OFS_PSRC, 32'hFFFF_FFFF);
		expect_reg("psrc_ro", OFS_PSRC, REG_RST);
		expect_reg("unmapped", 5'h1C, REG_RST);
		for (int i = 0; i < 3; i++)
		begin
			go(RUN_CTRL[i], RUN_CNT[i], RUN_DLY[i]);
			wait_end();
			check("acks", acks, RUN_CNT[i]);
			expect_reg("count", OFS_COUNT, 32'h0);
			expect_reg("src", OFS_SRC, RUN_SRC[i]);
			check("irq", end_interrupt_request, RUN_CTRL[i][4]);
			bus(1'b1, OFS_CTRL, 32'h0);
			repeat (2) @(negedge clk);
			check("irq_clr", end_interrupt_request, 1'b0);
		end
		// Stop causes: channel off, master off, nmi, address error
		for (int k = 0; k < 4; k++)
		begin
			go(STOP_CTRL[k], 8'h08, 4'h1);
			while (acks < 8'h02) @(negedge clk);
			case (k)
				0: bus(1'b1, OFS_CTRL, {23'h0, STOP_CTRL[k][8:1], 1'b0});
				1: bus(1'b1, OFS_GLOBAL, 32'h0);
				2: begin @(posedge clk) nmi_in <= 1'b1; repeat (4) @(posedge clk); nmi_in <= 1'b0; end
				default: begin @(posedge clk) address_error_in <= 1'b1; @(posedge clk); address_error_in <= 1'b0; end
			endcase
			repeat (40) @(negedge clk);
			check("stopped", bus_hold, 1'b0);
			bus(1'b0, OFS_CTRL, 32'h0);
			check("no_end", rd[8], 1'b0);
			bus(1'b0, OFS_COUNT, 32'h0);
			check("count_upd", rd, {24'h0, 8'h08 - acks});
			expect_reg("global", OFS_GLOBAL, STOP_GLB[k]);
			go(STOP_CTRL[k], 8'h04, 4'h1);
			wait_end();
			expect_reg("reload", OFS_SRC, 32'h0000_1000);
			bus(1'b1, OFS_CTRL, 32'h0);
		end
		complete_run();
	end
endmodule : test_dma_request_engine
bind dma_request_engine dma_request_engine_sva #(.ACC_STATES(ACC_STATES)) chk_i (.clk(clk),
	.rst(rst), .ahb_in(ahb_in), .ahb_out(ahb_out), .xfer_request_n(xfer_request_n),
	.nmi_in(nmi_in), .address_error_in(address_error_in), .chip_select_n(chip_select_n),
	.xfer_acknowledge(xfer_acknowledge), .end_interrupt_request(end_interrupt_request),
	.bus_hold(bus_hold), .dma_write(dma_write), .dma_address(dma_address));
